// File: core/dcap_map.svh
`ifndef DCAP_MAP_SVH
`define DCAP_MAP_SVH
`define DCAP_ROW_W        14
`define DCAP_COL_W        10
`define DCAP_BANK_W       3
`define DCAP_NBANK        8
`define DCAP_MR_W         2
`define DCAP_AP_BIT       10
`define DCAP_BC_BIT       12
`define DCAP_CYC_NS       10
`define DCAP_BURST_FULL   8
`define DCAP_BURST_CHOP   4
`endif

// File: core/dcap_pkg.sv
`include "dcap_map.svh"
package dcap_pkg;
  typedef enum logic [2:0] {
    DCAP_CMD_NOP  = 3'h7,
    DCAP_CMD_ACT  = 3'h3,
    DCAP_CMD_RD   = 3'h5,
    DCAP_CMD_WR   = 3'h4,
    DCAP_CMD_PRE  = 3'h2,
    DCAP_CMD_REF  = 3'h1,
    DCAP_CMD_MRS  = 3'h0,
    DCAP_CMD_ZQ   = 3'h6
  } dcap_cmd_e;

  typedef enum logic [1:0] {
    DCAP_PW_ON   = 2'h0,
    DCAP_PW_PPD  = 2'h1,
    DCAP_PW_APD  = 2'h2,
    DCAP_PW_SR   = 2'h3
  } dcap_pw_e;

  typedef struct packed {
    logic                    cs_n;
    logic                    ras_n;
    logic                    cas_n;
    logic                    we_n;
    logic [`DCAP_BANK_W-1:0] bank;
    logic [`DCAP_ROW_W-1:0]  addr;
  } dcap_ca_s;

  typedef struct packed {
    logic [2:0]              kind;
    logic [`DCAP_BANK_W-1:0] bank;
    logic [`DCAP_ROW_W-1:0]  row;
    logic [`DCAP_COL_W-1:0]  col;
    logic                    auto_pre;
    logic                    pre_all;
    logic                    full_burst;
  } dcap_op_s;
endpackage

// File: core/dcap_sync3.sv
module dcap_sync3 #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] chg_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign q_o   = s3;
  assign chg_o = s2 ^ s3;
endmodule // dcap_sync3

// File: core/dcap_ca_pins.sv
// How it works
// - address and control sampled only on the rising clock edge
// - clock enable high runs clocking, buffers and drivers; low stops them, the termination buffer only in self-refresh
// - clock enable low: precharge power-down or self-refresh idle, else active
// - clock enable is sampled synchronously for power-down and refresh entry
// - self-refresh exit seen from clock enable without a clock edge
// - power-down gates all inputs except clocks, termination, clock enable
// - self-refresh gates every input except clock enable
// - chip select high masks the command of that cycle
// - row, column strobes and write enable with select decode the command
// - masked write beats are not stored
// - write mask sampled on both strobe edges, one mask per beat
// - bank inputs pick one of eight banks for act, read, write, pre
// - bank inputs pick the mode register on a mode register set
// - bit 10 on read or write requests auto precharge after burst
// - bit 10 on precharge: low one bank, high all banks
// - address carries row on activate, column on read or write
// - mode register set takes its opcode from the address inputs
// - bit 12 high full burst, low chopped, when chop on the fly enabled
`include "dcap_map.svh"
module dcap_ca_pins
  import dcap_pkg::*;
#(
  parameter int NBANK = `DCAP_NBANK
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  input  wire logic                    ce_i,
  // pins
  input  wire dcap_ca_s                ca_i,
  input  wire logic                    cke_i,
  input  wire logic                    odt_i,
  input  wire logic                    upper_lane_write_mask_i,
  input  wire logic                    lower_lane_write_mask_i,
  input  wire logic                    upper_lane_strobe_i,
  input  wire logic                    lower_lane_strobe_i,
  // mode
  input  wire logic                    otf_chop_en_i,
  // decoded operation
  output dcap_op_s                     op_o,
  output logic                         op_valid_o,
  output logic [`DCAP_MR_W-1:0]        mr_sel_o,
  output logic [`DCAP_ROW_W-1:0]       mr_opcode_o,
  output logic                         mr_load_o,
  // banks and power
  output logic [NBANK-1:0]             bank_open_o,
  output dcap_pw_e                     pw_state_o,
  output logic                         clk_run_o,
  output logic                         ca_buf_en_o,
  output logic                         odt_buf_en_o,
  output logic                         drv_en_o,
  output logic                         odt_o,
  // write beat enables, one per strobe lane (upper in bit 1), set on either edge
  output logic [1:0]                   beat_we_o
);
  dcap_pw_e   pw_state;
  dcap_pw_e   next_pw;
  dcap_cmd_e  cmd;
  logic       cke_q;
  logic       cke_sync;
  logic       cke_chg;
  logic [1:0] strb_q;
  logic [1:0] mask_pin;
  logic       sr_low_seen;

  // decode command from the row, column strobe and write enable pins; select high gives nop
  function automatic dcap_cmd_e decode(input dcap_ca_s c);
    if (c.cs_n)
      return DCAP_CMD_NOP;
    else
      return dcap_cmd_e'({c.ras_n, c.cas_n, c.we_n});
  endfunction

  // asynchronous clock enable path for refresh exit
  dcap_sync3 #(.W(1)) u_cke_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (cke_i),
    .q_o    (cke_sync),
    .chg_o  (cke_chg)
  );

  always_comb begin
    cmd = decode(ca_i);
    if (pw_state != DCAP_PW_ON)
      cmd = DCAP_CMD_NOP;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i)
      cke_q <= 1'b0;
    else if (ce_i)
      cke_q <= cke_i;
  end

  always_comb begin
    next_pw = pw_state;
    case (pw_state)
      DCAP_PW_ON: begin
        if (!cke_i && cke_q) begin
          if (|bank_open_o)
            next_pw = DCAP_PW_APD;
          else if (cmd == DCAP_CMD_REF)
            next_pw = DCAP_PW_SR;
          else
            next_pw = DCAP_PW_PPD;
        end
      end
      DCAP_PW_PPD, DCAP_PW_APD: begin
        if (cke_i)
          next_pw = DCAP_PW_ON;
      end
      DCAP_PW_SR: begin
        // exit from synchronised level, no pin clock edge needed
        if (sr_low_seen && cke_sync && !cke_chg)
          next_pw = DCAP_PW_ON;
      end
      default: next_pw = DCAP_PW_ON;
    endcase
  end

  // arm exit only once the synchroniser has seen the pin low
  // right after entry it still carries the old high level
  always_ff @(posedge clk_i) begin
    if (srst_i)
      sr_low_seen <= 1'b0;
    else if (pw_state != DCAP_PW_SR)
      sr_low_seen <= 1'b0;
    else if (!cke_sync && !cke_chg)
      sr_low_seen <= 1'b1;
  end

  // refresh entry needs select low with refresh encoding
  always_ff @(posedge clk_i) begin
    if (srst_i)
      pw_state <= DCAP_PW_ON;
    else if (ce_i || pw_state == DCAP_PW_SR)
      pw_state <= next_pw;
  end

  always_comb begin
    clk_run_o    = (pw_state == DCAP_PW_ON) && cke_q;
    ca_buf_en_o  = (pw_state == DCAP_PW_ON);
    drv_en_o     = (pw_state == DCAP_PW_ON) && cke_q;
    odt_buf_en_o = (pw_state != DCAP_PW_SR);
  end

  assign pw_state_o = pw_state;

  // termination sampled while its buffer is on
  always_ff @(posedge clk_i) begin
    if (srst_i)
      odt_o <= 1'b0;
    else if (ce_i && odt_buf_en_o)
      odt_o <= odt_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      op_o       <= '0;
      op_valid_o <= 1'b0;
    end else if (ce_i) begin
      op_valid_o <= (cmd != DCAP_CMD_NOP);
      op_o.kind  <= cmd;
      op_o.bank  <= ca_i.bank;
      op_o.row   <= ca_i.addr;
      op_o.col   <= ca_i.addr[`DCAP_COL_W-1:0];
      op_o.auto_pre <= ((cmd == DCAP_CMD_RD) || (cmd == DCAP_CMD_WR))
                       && ca_i.addr[`DCAP_AP_BIT];
      op_o.pre_all  <= (cmd == DCAP_CMD_PRE) && ca_i.addr[`DCAP_AP_BIT];
      op_o.full_burst <= !otf_chop_en_i || ca_i.addr[`DCAP_BC_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i)
      bank_open_o <= '0;
    else if (ce_i) begin
      if (cmd == DCAP_CMD_ACT)
        bank_open_o[ca_i.bank] <= 1'b1;
      else if (cmd == DCAP_CMD_PRE) begin
        if (ca_i.addr[`DCAP_AP_BIT])
          bank_open_o <= '0;
        else
          bank_open_o[ca_i.bank] <= 1'b0;
      end else if ((cmd == DCAP_CMD_RD || cmd == DCAP_CMD_WR)
                   && ca_i.addr[`DCAP_AP_BIT])
        bank_open_o[ca_i.bank] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mr_sel_o    <= '0;
      mr_opcode_o <= '0;
      mr_load_o   <= 1'b0;
    end else if (ce_i) begin
      mr_load_o <= (cmd == DCAP_CMD_MRS);
      if (cmd == DCAP_CMD_MRS) begin
        mr_sel_o    <= ca_i.bank[`DCAP_MR_W-1:0];
        mr_opcode_o <= ca_i.addr;
      end
    end
  end

  // mask per beat on either strobe edge
  assign mask_pin = {upper_lane_write_mask_i, lower_lane_write_mask_i};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strb_q    <= '0;
      beat_we_o <= '0;
    end else if (ce_i) begin
      strb_q <= {upper_lane_strobe_i, lower_lane_strobe_i};
      beat_we_o <= (strb_q ^ {upper_lane_strobe_i, lower_lane_strobe_i})
                   & ~mask_pin & {2{ca_buf_en_o}};
    end
  end

  // assertion clock and reset
  default clocking dcap_cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // self-refresh exit steps
  sequence s_in_sr;
    pw_state == DCAP_PW_SR;
  endsequence

  sequence s_cke_settled_high;
    sr_low_seen && cke_sync && !cke_chg;
  endsequence

  a_cs_masks_cmd: assert property (
    ce_i && ca_i.cs_n |=> !op_valid_o)
    else $error("command issued with select high");

  a_pre_all_close: assert property (
    ce_i && decode(ca_i) == DCAP_CMD_PRE && ca_i.addr[`DCAP_AP_BIT]
    && pw_state == DCAP_PW_ON |=> bank_open_o == '0)
    else $error("precharge all left a bank open");

  a_act_opens: assert property (
    ce_i && cmd == DCAP_CMD_ACT |=> bank_open_o[$past(ca_i.bank)])
    else $error("activate did not open bank");

  // active power-down with an open row
  a_apd_entry: assert property (
    ce_i && pw_state == DCAP_PW_ON && cke_q && !cke_i && |bank_open_o
    |=> pw_state == DCAP_PW_APD)
    else $error("open row did not enter active power-down");

  // refresh with clock enable falling and idle banks
  a_sr_entry: assert property (
    ce_i && pw_state == DCAP_PW_ON && cke_q && !cke_i && !(|bank_open_o)
    && cmd == DCAP_CMD_REF |=> pw_state == DCAP_PW_SR)
    else $error("idle refresh did not enter self-refresh");

  // settled high clock enable leaves self-refresh
  a_sr_exit: assert property (
    s_in_sr ##0 s_cke_settled_high |=> pw_state == DCAP_PW_ON)
    else $error("self-refresh exit missed");

  // no clocking or drivers outside the on state
  a_pd_drv_off: assert property (
    pw_state != DCAP_PW_ON |-> !clk_run_o && !drv_en_o)
    else $error("clock or drivers active while powered down");

  // no inputs except clock enable during refresh
  a_sr_gate: assert property (
    pw_state == DCAP_PW_SR |-> !ca_buf_en_o && !odt_buf_en_o
    && !clk_run_o)
    else $error("buffer active in self-refresh");

  // termination buffer stays on in power-down
  a_pd_gate: assert property (
    pw_state inside {DCAP_PW_PPD, DCAP_PW_APD}
    |-> odt_buf_en_o && !ca_buf_en_o)
    else $error("power-down gating wrong");

  // read with bit 10 flags auto precharge
  a_auto_pre: assert property (
    ce_i && cmd == DCAP_CMD_RD ##1 ce_i
    |-> op_o.auto_pre == $past(ca_i.addr[`DCAP_AP_BIT]))
    else $error("auto precharge flag wrong");

  // column taken from low address bits
  a_col_addr: assert property (
    ce_i && (cmd == DCAP_CMD_RD || cmd == DCAP_CMD_WR)
    |=> op_o.col == $past(ca_i.addr[`DCAP_COL_W-1:0]))
    else $error("column address wrong");

  a_burst_len: assert property (
    ce_i && (cmd == DCAP_CMD_RD || cmd == DCAP_CMD_WR)
    |=> op_o.full_burst
        == ($past(!otf_chop_en_i) || $past(ca_i.addr[`DCAP_BC_BIT])))
    else $error("burst chop selection wrong");

  a_mrs_opcode: assert property (
    ce_i && cmd == DCAP_CMD_MRS |=> mr_load_o
    && mr_opcode_o == $past(ca_i.addr))
    else $error("mode register opcode wrong");

  a_mask_beat: assert property (
    ce_i && upper_lane_write_mask_i |=> !beat_we_o[1])
    else $error("masked upper beat written");

  a_mask_low: assert property (
    ce_i && lower_lane_write_mask_i |=> !beat_we_o[0])
    else $error("masked lower beat written");
endmodule // dcap_ca_pins

// File: testbench/dcap_host.sv
module dcap_host
  import dcap_pkg::*;
(
  // clock
  input  wire logic clk_i,
  // pins
  output dcap_ca_s   ca_o,
  output logic       cke_o,
  output logic       odt_o,
  output logic [1:0] dm_o,
  output logic [1:0] dqs_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ca_o  = {4'hF, 17'h0};
    cke_o = 1'b0;
    odt_o = 1'b0;
    dm_o  = 2'h0;
    dqs_o = 2'h0;
  end

  task automatic issue(input dcap_cmd_e c, input logic [2:0] b,
                       input logic [13:0] a, input logic sel_n,
                       input logic ck);
    @(posedge clk_i);
    ca_o  <= {sel_n, c, b, a};
    odt_o <= a[0];
    cke_o <= (c == DCAP_CMD_RD || c == DCAP_CMD_WR) ? 1'b1 : ck;
    @(posedge clk_i);
    // released bus shows inverse
    ca_o  <= {4'hF, ~b, ~a};
  endtask

  task automatic beat(input logic [1:0] tg, input logic [1:0] m);
    @(posedge clk_i);
    dqs_o <= dqs_o ^ tg;
    dm_o  <= m;
    @(posedge clk_i);
    dm_o  <= ~m;
  endtask
endmodule // dcap_host

// File: testbench/dcap_ca_pins_bench.sv
module dcap_ca_pins_bench
  import dcap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_i, srst_i, otf, s, odt, cke, mr_load_o, op_valid_o;
  logic       clk_run_o, ca_buf_en_o, odt_buf_en_o, drv_en_o, odt_o;
  logic [1:0] dm, dqs, mr_sel_o, beat_we_o, we;
  logic [13:0] mr_opcode_o;
  logic [7:0] bank_open_o;
  dcap_ca_s   ca;
  dcap_op_s   op_o;
  dcap_pw_e   pw_state_o;
  int         err_count, n_compared, cyc;

  dcap_host i_host (.clk_i(clk_i), .ca_o(ca), .cke_o(cke), .odt_o(odt),
                    .dm_o(dm), .dqs_o(dqs));
  dcap_ca_pins i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .ca_i(ca), .cke_i(cke),
    .odt_i(odt), .upper_lane_write_mask_i(dm[1]),
    .lower_lane_write_mask_i(dm[0]), .upper_lane_strobe_i(dqs[1]),
    .lower_lane_strobe_i(dqs[0]), .otf_chop_en_i(otf), .op_o(op_o),
    .op_valid_o(op_valid_o), .mr_sel_o(mr_sel_o),
    .mr_opcode_o(mr_opcode_o), .mr_load_o(mr_load_o),
    .bank_open_o(bank_open_o), .pw_state_o(pw_state_o),
    .clk_run_o(clk_run_o), .ca_buf_en_o(ca_buf_en_o),
    .odt_buf_en_o(odt_buf_en_o), .drv_en_o(drv_en_o), .odt_o(odt_o),
    .beat_we_o(beat_we_o));

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  task automatic end_sim;
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // polls a few settled points for a decoded pulse
  task automatic wait_op(input logic exp);
    s = 1'b0;
    for (int i = 0; i < 4 && !s; i++) begin
      #1;
      s = (op_valid_o === 1'b1) || (mr_load_o === 1'b1);
      if (!s) @(posedge clk_i);
    end
    chk(s, exp);
  endtask

  task automatic wait_pw(input dcap_pw_e exp);
    for (int i = 0; i < 8 && pw_state_o !== exp; i++) @(posedge clk_i);
    #1;
    chk(pw_state_o, exp);
  endtask

  task automatic t_act_pre;
    i_host.issue(DCAP_CMD_ACT, 3'h3, 14'h2A5C, 1'b0, 1'b1);
    wait_op(1'b1);
    chk(op_o.kind, DCAP_CMD_ACT);
    chk(op_o.row, 14'h2A5C);
    chk({op_o.bank, odt_o}, 4'h6);
    i_host.issue(DCAP_CMD_ACT, 3'h5, 14'h0111, 1'b0, 1'b1);
    wait_op(1'b1);
    chk(bank_open_o, 8'h28);
    chk({op_o.bank, odt_o}, 4'hB);
    i_host.issue(DCAP_CMD_PRE, 3'h3, 14'h0000, 1'b0, 1'b1);
    wait_op(1'b1);
    chk({op_o.pre_all, bank_open_o}, 9'h020);
    i_host.issue(DCAP_CMD_PRE, 3'h6, 14'h0400, 1'b0, 1'b1);
    wait_op(1'b1);
    chk({op_o.pre_all, bank_open_o}, 9'h100);
  endtask

  task automatic t_cs_mask;
    i_host.issue(DCAP_CMD_ZQ, 3'h0, 14'h0, 1'b0, 1'b1);
    wait_op(1'b1);
    chk(op_o.kind, DCAP_CMD_ZQ);
    i_host.issue(DCAP_CMD_ACT, 3'h1, 14'h0042, 1'b1, 1'b1);
    wait_op(1'b0);
    chk(bank_open_o, 8'h00);
  endtask

  task automatic t_rdwr;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) otf <= i[1];
      i_host.issue(i[0] ? DCAP_CMD_WR : DCAP_CMD_RD, 3'h2,
                   {1'b0, i[0], 1'b0, i[0] ^ i[1], 10'h1A5 + 10'(i)},
                   1'b0, 1'b1);
      wait_op(1'b1);
      chk(op_o.col, 10'h1A5 + 10'(i));
      chk(op_o.auto_pre, i[0] ^ i[1]);
      chk(op_o.full_burst, {i[0] | ~i[1]});
    end
  endtask

  task automatic t_mrs;
    for (int b = 0; b < 4; b++) begin
      i_host.issue(DCAP_CMD_MRS, 3'(b), 14'h1230 + 14'(b), 1'b0, 1'b1);
      wait_op(1'b1);
      chk(mr_load_o, 1'b1);
      chk({mr_sel_o, mr_opcode_o}, {2'(b), 14'h1230 + 14'(b)});
    end
  endtask

  task automatic t_power;
    i_host.issue(DCAP_CMD_NOP, 3'h0, 14'h0, 1'b1, 1'b0);
    wait_pw(DCAP_PW_PPD);
    chk({clk_run_o, drv_en_o, ca_buf_en_o, odt_buf_en_o}, 4'h1);
    i_host.issue(DCAP_CMD_ACT, 3'h4, 14'h0009, 1'b0, 1'b0);
    wait_op(1'b0);
    chk(odt_o, 1'b1);
    i_host.issue(DCAP_CMD_NOP, 3'h0, 14'h0, 1'b1, 1'b1);
    wait_pw(DCAP_PW_ON);
    chk({clk_run_o, drv_en_o, ca_buf_en_o, odt_buf_en_o}, 4'hF);
    i_host.issue(DCAP_CMD_ACT, 3'h4, 14'h0008, 1'b0, 1'b1);
    i_host.issue(DCAP_CMD_NOP, 3'h0, 14'h0, 1'b1, 1'b0);
    wait_pw(DCAP_PW_APD);
    i_host.issue(DCAP_CMD_NOP, 3'h0, 14'h0, 1'b1, 1'b1);
    wait_pw(DCAP_PW_ON);
    i_host.issue(DCAP_CMD_PRE, 3'h0, 14'h0400, 1'b0, 1'b1);
    i_host.issue(DCAP_CMD_REF, 3'h0, 14'h0, 1'b0, 1'b0);
    wait_pw(DCAP_PW_SR);
    chk({clk_run_o, ca_buf_en_o, odt_buf_en_o}, 3'h0);
    i_host.issue(DCAP_CMD_NOP, 3'h0, 14'h0, 1'b1, 1'b1);
    wait_pw(DCAP_PW_ON);
  endtask

  task automatic t_mask;
    logic [3:0] tbl [5] = '{4'hC, 4'hD, 4'hE, 4'hF, 4'h8};
    i_host.issue(DCAP_CMD_ACT, 3'h1, 14'h0003, 1'b0, 1'b1);
    i_host.issue(DCAP_CMD_WR, 3'h1, 14'h0010, 1'b0, 1'b1);
    foreach (tbl[i]) begin
      i_host.beat(tbl[i][3:2], tbl[i][1:0]);
      we = 2'h0;
      repeat (2) begin
        #1 we |= beat_we_o;
        @(posedge clk_i);
      end
      chk(we, tbl[i][3:2] & ~tbl[i][1:0]);
    end
  endtask

  initial begin
    srst_i = 1'b1;
    otf = 1'b0;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    t_act_pre();
    t_cs_mask();
    t_power();
    t_rdwr();
    t_mrs();
    t_mask();
    end_sim();
  end
endmodule // dcap_ca_pins_bench
